// ### include/cxs_pkg.sv
// Package of constants and types for the CPU exception sequencer
//
// Contract
// - Accept reset, trace, direct, interrupt, trap by priority
// - Reset handling starts on pin rise or watchdog
// - Reset pin low holds CPU in reset
// - Trace enable starts trace at instruction boundary
// - Trace only in mode 2, never after return
// - Pending interrupt taken at instruction boundary
// - No interrupt sampling after control writes or reset
// - Trap instruction accepted always in execution state; code accepts it in ST_RUN only, not during the first instruction (ST_FIRST)
// - No direct transition, manual reset or normal mode
// - Four-byte vectors; reset 0, trace 5, NMI 7
// - Traps vectors 8-11; external interrupts 16-31
// - Peripheral interrupts use vectors 32 through 99
// - Vector address upper bits are zero
// - Reset clears state; interrupt control mode zero
// - Reset clears trace, sets mask, loads vector
// - All interrupts blocked until first instruction runs
// - Module stop register becomes 0fff at release
// - Stopped module register access has no effect
// - Push PC, flags, extended; then mask, vector fetch
// - Trap sets mask; mode 2 clears trace
package cxs_pkg;

  // ****************************************************************
  // Vector numbers and layout
  // ****************************************************************
  localparam logic [6:0]  VEC_RESET     = 7'h00;
  localparam logic [6:0]  VEC_TRACE     = 7'h05;
  localparam logic [6:0]  VEC_NMI       = 7'h07;
  localparam logic [6:0]  VEC_TRAP_BASE = 7'h08;
  localparam logic [6:0]  VEC_EXT_BASE  = 7'h10;
  localparam logic [6:0]  VEC_INT_FIRST = 7'h20;
  localparam logic [6:0]  VEC_INT_LAST  = 7'h63;
  localparam int          VEC_SHIFT     = 2;
  localparam int          ADDR_W        = 24;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [15:0] MSTOP_RESET   = 16'h0fff;
  localparam logic [1:0]  INTM_RESET    = 2'h0;
  localparam logic [1:0]  INTM_MODE2    = 2'h2;
  localparam int          RES_MIN_STATES = 20;

  // Interrupt request from the interrupt controller
  typedef struct packed {
    logic       req;
    logic       nmi;
    logic [6:0] vec;
  } cxs_irq_t;

  // Exception kind being sequenced
  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESET, EXC_TRACE, EXC_INTR, EXC_TRAP
  } cxs_exc_t;

endpackage

// ### rtl/cxs_seq.sv
// CPU exception sequencer: ranking, vectoring, reset and module stop
`timescale 1ns/1ps
`default_nettype none
module cxs_seq (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Reset sources
  input  wire logic             reset_input_pin_n_i,
  input  wire logic             wdt_ovf_i,
  // Interrupt controller
  input  wire cxs_pkg::cxs_irq_t irq_i,
  input  wire logic [1:0]       intm_i,
  // CPU execution path
  input  wire logic             insn_done_i,
  input  wire logic             was_rte_i,
  input  wire logic             was_ctl_write_i,
  input  wire logic             trap_i,
  input  wire logic [1:0]       trap_num_i,
  input  wire logic             push_done_i,
  input  wire logic             vec_ack_i,
  input  wire logic             trace_en_i,
  // Peripheral register access
  input  wire logic [3:0]       per_sel_i,
  input  wire logic             per_req_i,
  input  wire logic             mstop_wr_i,
  input  wire logic [15:0]      mstop_wdata_i,
  // Outputs
  output logic                  cpu_halt_o,
  output logic                  push_req_o,
  output logic                  vec_req_o,
  output logic [23:0]           vec_addr_o,
  output logic                  set_imask_o,
  output logic                  clr_trace_o,
  output logic                  exc_busy_o,
  output logic [1:0]            intm_o,
  output logic [15:0]           module_stop_control_register_o,
  output logic                  per_access_ok_o
);
  import cxs_pkg::*;

  // ****************************************************************
  // Synchronisers for the reset pin and watchdog
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RESET, ST_RVEC, ST_RUN, ST_FIRST, ST_PUSH, ST_VEC
  } cxs_state_t;

  logic       pin_s1_q, pin_s2_q, pin_s3_q;
  logic       wdt_s1_q, wdt_s2_q;
  cxs_state_t state_q, state_d;
  cxs_exc_t   kind_q, kind_d;
  logic [6:0] vec_q, vec_d;
  logic       blk_q, blk_d;
  logic [15:0] mstop_q;
  logic [1:0] intm_q;

  // Two stages before use; third stage only for edge detection
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      wdt_s1_q <= 1'b0;
      wdt_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= reset_input_pin_n_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      wdt_s1_q <= wdt_ovf_i;
      wdt_s2_q <= wdt_s1_q;
    end
  end

  // ****************************************************************
  // Acceptance decode
  // ****************************************************************
  wire pin_low  = ~pin_s2_q;
  wire pin_rise = pin_s2_q & ~pin_s3_q;
  wire wdt_hit  = wdt_s2_q;
  wire in_run   = (state_q == ST_RUN);
  // Trace needs mode 2 and must not follow a return
  wire take_trace = in_run & insn_done_i & trace_en_i
                  & (intm_q == INTM_MODE2) & ~was_rte_i;
  // Interrupts skipped after control writes or until first insn ran
  wire take_intr  = in_run & insn_done_i & irq_i.req
                  & ~was_ctl_write_i & ~blk_q;
  wire take_trap  = in_run & trap_i;
  // Vector of the interrupt: NMI, external or peripheral
  wire [6:0] intr_vec = irq_i.nmi ? VEC_NMI : irq_i.vec;
  wire [6:0] trap_vec = VEC_TRAP_BASE + {5'h00, trap_num_i};

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  // Reset outranks everything; direct transition does not exist here
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    vec_d   = vec_q;
    blk_d   = blk_q;
    if (pin_low || wdt_hit) begin
      state_d = ST_RESET;
      kind_d  = EXC_RESET;
      vec_d   = VEC_RESET;
      blk_d   = 1'b1;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          // Pin release or a watchdog pulse that has ended
          if (pin_rise || kind_q == EXC_RESET) begin
            state_d = ST_RVEC;
          end
        end
        ST_RVEC: begin
          if (vec_ack_i) begin
            state_d = ST_FIRST;
            kind_d  = EXC_NONE;
          end
        end
        ST_FIRST: begin
          // First instruction runs with every interrupt blocked
          if (insn_done_i) begin
            state_d = ST_RUN;
            blk_d   = 1'b0;
          end
        end
        ST_RUN: begin
          if (take_trace) begin
            state_d = ST_PUSH;
            kind_d  = EXC_TRACE;
            vec_d   = VEC_TRACE;
          end else if (take_intr) begin
            state_d = ST_PUSH;
            kind_d  = EXC_INTR;
            vec_d   = intr_vec;
          end else if (take_trap) begin
            state_d = ST_PUSH;
            kind_d  = EXC_TRAP;
            vec_d   = trap_vec;
          end
        end
        ST_PUSH: begin
          if (push_done_i) begin
            state_d = ST_VEC;
          end
        end
        ST_VEC: begin
          if (vec_ack_i) begin
            state_d = ST_RUN;
            kind_d  = EXC_NONE;
          end
        end
        default: state_d = ST_RESET;
      endcase
    end
  end

  // Short state register; reset restores defined control state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
      kind_q  <= EXC_NONE;
      vec_q   <= VEC_RESET;
      blk_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      vec_q   <= vec_d;
      blk_q   <= blk_d;
    end
  end

  // ****************************************************************
  // Mode and module stop registers
  // ****************************************************************
  // Mode forced to 0 in reset; the controller sets it afterwards
  always_ff @(posedge mclk_i) begin
    if (rst_i || state_q == ST_RESET) begin
      intm_q <= INTM_RESET;
    end else begin
      intm_q <= intm_i;
    end
  end

  // Written only outside reset so the release value is fixed
  always_ff @(posedge mclk_i) begin
    if (rst_i || state_q == ST_RESET) begin
      mstop_q <= MSTOP_RESET;
    end else if (mstop_wr_i) begin
      mstop_q <= mstop_wdata_i;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire in_vec = (state_q == ST_VEC) | (state_q == ST_RVEC);
  // Vector number times four, upper address bits zero
  wire [23:0] addr_w = {15'h0000, vec_q, 2'b00};
  // Mask set on every vector fetch; trace cleared except on traps outside mode 2
  wire clr_tr = (kind_q == EXC_RESET)
              | (kind_q == EXC_TRAP & intm_q == INTM_MODE2)
              | (kind_q == EXC_INTR)
              | (kind_q == EXC_TRACE);
  // Stopped modules see no access at all
  wire acc_ok = per_req_i & ~mstop_q[per_sel_i];

  assign cpu_halt_o  = (state_q == ST_RESET);
  assign push_req_o  = (state_q == ST_PUSH);
  assign vec_req_o   = in_vec;
  assign set_imask_o = in_vec;
  assign clr_trace_o = in_vec & clr_tr;
  assign exc_busy_o  = (state_q != ST_RUN) & (state_q != ST_FIRST);
  assign intm_o      = intm_q;
  assign per_access_ok_o = acc_ok;
  assign module_stop_control_register_o = mstop_q;

  // Vector address held in a flop for a stable fetch
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vec_addr_o <= 24'h000000;
    end else begin
      vec_addr_o <= addr_w;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Reset and watchdog hold the core, then fetch vector 0
  a_reset_halts: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    pin_low |=> cpu_halt_o)
    else $error("Reset pin low did not halt");
  a_wdt_halts: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wdt_hit |=> cpu_halt_o)
    else $error("Watchdog overflow did not halt");
  a_reset_vec: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_RVEC) |-> vec_req_o && vec_addr_o == 24'h000000)
    else $error("Reset vector address wrong");
  a_reset_flags: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_RVEC) |-> set_imask_o && clr_trace_o)
    else $error("Reset did not set mask and clear trace");
  a_intm_reset: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_RESET) |=> intm_o == INTM_RESET)
    else $error("Mode not zero after reset");
  a_mstop_reset: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_RESET) |=> module_stop_control_register_o == MSTOP_RESET)
    else $error("Module stop not forced in reset");
  a_mstop_rel: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_RESET) ##1 (state_q == ST_RVEC)
      |-> module_stop_control_register_o == 16'h0fff)
    else $error("Module stop not set at release");
  a_no_irq_first: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_FIRST) |=> !(kind_q == EXC_INTR))
    else $error("Interrupt taken before first insn");
  a_first_block: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_FIRST) |-> blk_q && !exc_busy_o)
    else $error("Interrupts open before first insn");
  // Acceptance follows the ranking and the refusals
  a_trace_first: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take_trace && take_intr && !pin_low && !wdt_hit)
      |=> kind_q == EXC_TRACE)
    else $error("Priority order broken");
  a_trace_take: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take_trace && !pin_low && !wdt_hit)
      |=> state_q == ST_PUSH && vec_q == VEC_TRACE)
    else $error("Trace not taken");
  a_trace_mode2: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_PUSH && kind_q == EXC_TRACE) |-> $past(intm_q) == INTM_MODE2)
    else $error("Trace taken outside mode 2");
  a_trace_mode0: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (in_run && insn_done_i && intm_q != INTM_MODE2 && !irq_i.req
     && !trap_i && !pin_low && !wdt_hit) |=> state_q != ST_PUSH)
    else $error("Exception taken in mode 0 without source");
  a_trace_rte: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (in_run && insn_done_i && was_rte_i && !take_intr && !trap_i
     && !pin_low && !wdt_hit) |=> state_q != ST_PUSH)
    else $error("Trace taken after return");
  a_irq_take: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take_intr && !take_trace && !pin_low && !wdt_hit)
      |=> state_q == ST_PUSH && kind_q == EXC_INTR)
    else $error("Pending interrupt not taken");
  a_nmi_vec: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take_intr && irq_i.nmi && !take_trace && !pin_low && !wdt_hit)
      |=> vec_q == VEC_NMI)
    else $error("NMI vector wrong");
  a_ctl_no_irq: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (in_run && was_ctl_write_i && !take_trace && !trap_i
     && !pin_low && !wdt_hit) |=> state_q != ST_PUSH)
    else $error("Interrupt sampled after control write");
  a_trap_accept: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take_trap && !pin_low && !wdt_hit) |=> state_q == ST_PUSH)
    else $error("Trap not accepted");
  a_trap_vec: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take_trap && !take_trace && !take_intr && !pin_low && !wdt_hit)
      |=> vec_q[6:2] == 5'h02 && vec_q[1:0] == $past(trap_num_i))
    else $error("Trap vector wrong");
  // Stacking, then the vector fetch with its flag updates
  a_push_order: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_VEC && $past(state_q) != ST_VEC)
      |-> $past(state_q) == ST_PUSH)
    else $error("Vector fetch before push");
  a_push_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (push_req_o && !push_done_i && !pin_low && !wdt_hit) |=> push_req_o)
    else $error("Push request dropped early");
  a_vec_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (vec_req_o && !vec_ack_i && !pin_low && !wdt_hit)
      |=> vec_req_o && $stable(vec_addr_o))
    else $error("Vector fetch not held");
  a_vec_map: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    vec_req_o |-> vec_addr_o[8:2] == vec_q && vec_addr_o[1:0] == 2'b00)
    else $error("Vector address not number times four");
  a_vec_upper: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    vec_req_o |-> vec_addr_o[23:9] == 15'h0000)
    else $error("Vector upper bits not zero");
  a_trap_flags: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (vec_req_o && kind_q == EXC_TRAP)
      |-> set_imask_o && clr_trace_o == (intm_q == INTM_MODE2))
    else $error("Trap flag update wrong");
  a_irq_flags: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (vec_req_o && kind_q == EXC_INTR) |-> set_imask_o && clr_trace_o)
    else $error("Interrupt flag update wrong");
  // Module stop gates every peripheral access
  a_stop_block: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    mstop_q[per_sel_i] |-> !per_access_ok_o)
    else $error("Access to stopped module");
  a_stop_open: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (per_req_i && !mstop_q[per_sel_i]) |-> per_access_ok_o)
    else $error("Access to running module refused");

endmodule
`default_nettype wire

// ### tb/cxs_partner.sv
// Model of the stacking and vector memory side facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module cxs_partner (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Requests from the sequencer and chosen answer delay
  input  wire logic       push_req_i,
  input  wire logic       vec_req_i,
  input  wire logic [1:0] dly_i,
  // Completion pulses
  output logic            push_done_o,
  output logic            vec_ack_o
);
  logic [1:0] cnt_q;
  wire  logic hold_w;

  // Rearm after each pulse so one request never sees two answers
  assign hold_w = rst_i || !(push_req_i || vec_req_i) || push_done_o ||
                  vec_ack_o;

  // Answer after dly_i wait cycles, prompt or slow as the bench asks
  always_ff @(posedge mclk_i) begin
    push_done_o <= 1'b0;
    vec_ack_o   <= 1'b0;
    if (hold_w) begin
      cnt_q <= 2'h0;
    end else if (cnt_q >= dly_i) begin
      push_done_o <= push_req_i;
      vec_ack_o   <= vec_req_i;
      cnt_q       <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/cxs_seq_tb_top.sv
// Self-checking bench for the CPU exception sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  fails++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module cxs_seq_tb_top;
  import cxs_pkg::*;
  // ****************************************************************
  // Signals, design and partner
  // ****************************************************************
  typedef struct packed {logic [23:0] a; logic m; logic t;} cxs_exp_t;
  cxs_exp_t   exp_q[$];
  cxs_exp_t   e;
  int         fails, n_compared;
  logic       mclk_i, rst_i, pin_n, wdt, ins, return_from_exception, ctl, trp, ten, prq, mwr;
  cxs_irq_t   irq_i;
  logic [1:0] intm_i, tnum, dly;
  logic [3:0] psel;
  logic [15:0] mdat;
  wire logic  halt, preq, vreq, pdone, vack, smask, ctr, busy, pok;
  wire logic [23:0] vaddr;
  wire logic [1:0]  intm_o;
  wire logic [15:0] mstop;

  cxs_seq u_cxs_seq (.mclk_i(mclk_i), .rst_i(rst_i),
    .reset_input_pin_n_i(pin_n), .wdt_ovf_i(wdt), .irq_i(irq_i),
    .intm_i(intm_i), .insn_done_i(ins), .was_rte_i(return_from_exception),
    .was_ctl_write_i(ctl), .trap_i(trp), .trap_num_i(tnum),
    .push_done_i(pdone), .vec_ack_i(vack), .trace_en_i(ten),
    .per_sel_i(psel), .per_req_i(prq), .mstop_wr_i(mwr),
    .mstop_wdata_i(mdat), .cpu_halt_o(halt), .push_req_o(preq),
    .vec_req_o(vreq), .vec_addr_o(vaddr), .set_imask_o(smask),
    .clr_trace_o(ctr), .exc_busy_o(busy), .intm_o(intm_o),
    .module_stop_control_register_o(mstop), .per_access_ok_o(pok));
  cxs_partner u_cxs_partner (.mclk_i(mclk_i), .rst_i(rst_i),
    .push_req_i(preq), .vec_req_i(vreq), .dly_i(dly),
    .push_done_o(pdone), .vec_ack_o(vack));

  // Free-running 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Each finished vector fetch is matched to the oldest expectation
  always @(posedge mclk_i) begin
    if (vreq === 1'b1 && vack === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      `CHK("vec_addr", e.a, vaddr)
      `CHK("clr_trace", e.t, ctr)
      if (e.m) `CHK("set_imask", 1'b1, smask)
    end
    if (pdone === 1'b1) `CHK("push_req", 1'b1, preq)
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Flag waits are bounded so a stuck sequencer cannot hang the run
  task automatic idle();
    int k;
    k = 0;
    repeat (2) @(posedge mclk_i);
    #1;
    while ((busy !== 1'b0 || halt !== 1'b0) && k < 60) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    `CHK("busy", 1'b0, busy)
  endtask

  // One instruction boundary, with its qualifiers
  task automatic insn(input logic c, input logic r);
    @(posedge mclk_i);
    ins <= 1'b1;
    ctl <= c;
    return_from_exception <= r;
    dly <= 2'($urandom % 4);
    @(posedge mclk_i);
    ins <= 1'b0;
    ctl <= 1'b0;
    return_from_exception <= 1'b0;
  endtask

  // A boundary that must start nothing
  task automatic none(input logic c, input logic r);
    insn(c, r);
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK("no_exc", 1'b0, busy)
  endtask

  // Reset handling, then the first instruction with a request pending
  task automatic rtail();
    idle();
    insn(1'b0, 1'b0);
    irq_i <= '0;
  endtask

  task automatic report_and_stop();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    int v, n;
    {rst_i, pin_n} = 2'b11;
    {wdt, ins, return_from_exception, ctl, trp, ten, prq, mwr} = '0;
    {irq_i, intm_i, tnum, dly, psel, mdat} = '0;
    v = $urandom(89);
    repeat (16) @(posedge mclk_i);
    `CHK("halt", 1'b1, halt)
    `CHK("mstop", 16'h0fff, mstop)
    `CHK("intm", 2'h0, intm_o)
    exp_q.push_back({24'h0, 2'b11});
    irq_i <= '{1'b1, 1'b1, 7'h10};
    rst_i <= 1'b0;
    rtail();
    for (n = 0; n < 8; n++) begin
      @(posedge mclk_i);
      intm_i <= n[2] ? 2'h2 : 2'h0;
      @(posedge mclk_i);
      trp  <= 1'b1;
      tnum <= n[1:0];
      exp_q.push_back({24'h20 + 24'(n % 4) * 24'h4, 1'b1, n[2]});
      @(posedge mclk_i);
      trp <= 1'b0;
      idle();
      `CHK("intm", n[2] ? 2'h2 : 2'h0, intm_o)
    end
    intm_i <= 2'h0;
    for (n = 0; n < 6; n++) begin
      v = (n == 0) ? 7 : 16 + $urandom % 84;
      irq_i <= '{1'b1, n == 0, (n == 0) ? 7'h30 : 7'(v)};
      exp_q.push_back({24'(v * 4), 2'b01});
      insn(1'b0, 1'b0);
      irq_i <= '0;
      idle();
    end
    irq_i <= '{1'b1, 1'b0, 7'h11};
    none(1'b1, 1'b0);
    intm_i <= 2'h2;
    ten    <= 1'b1;
    exp_q.push_back({24'h14, 2'b01});
    insn(1'b0, 1'b0);
    irq_i <= '0;
    idle();
    none(1'b0, 1'b1);
    intm_i <= 2'h0;
    none(1'b0, 1'b0);
    ten <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(posedge mclk_i);
      mwr  <= 1'b1;
      mdat <= 16'($urandom);
      @(posedge mclk_i);
      mwr  <= 1'b0;
      prq  <= 1'b1;
      psel <= 4'($urandom);
      @(posedge mclk_i);
      #1;
      `CHK("per_ok", ~mdat[psel], pok)
    end
    prq <= 1'b0;
    for (n = 0; n < 2; n++) begin
      @(posedge mclk_i);
      irq_i <= '{1'b1, 1'b0, 7'h12};
      exp_q.push_back({24'h0, 2'b11});
      if (n == 0) begin
        pin_n <= 1'b0;
        repeat (20) @(posedge mclk_i);
        `CHK("halt", 1'b1, halt)
        `CHK("mstop", 16'h0fff, mstop)
        pin_n <= 1'b1;
      end else begin
        wdt <= 1'b1;
        @(posedge mclk_i);
        wdt <= 1'b0;
      end
      rtail();
    end
    idle();
    `CHK("left", 0, exp_q.size())
    report_and_stop();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
